/* tir_defs.vh */
// Constants for the thermistor readout block: map, fields, resets, timing
`ifndef TIR_DEFS_VH
`define TIR_DEFS_VH
`define TIR_CLK_NS 4
`define TIR_SLOW_NS 125000000
`define TIR_FAST_NS 4000000
`define TIR_NCHAN 8
`define TIR_AW 8
`define TIR_A_STATUS 8'h00
`define TIR_A_CONFIG 8'h04
`define TIR_A_SCALE 8'h08
`define TIR_A_RAWLIM 8'h0C
`define TIR_A_ENGMIN 8'h10
`define TIR_A_ENGMAX 8'h14
`define TIR_A_UPC 8'h18
`define TIR_A_RAW0 8'h20
`define TIR_A_SCL0 8'h40
`define TIR_A_END 8'h60
`define TIR_ST_SELFTEST 0
`define TIR_ST_NOSUPPLY 1
`define TIR_ST_CFGBAD 2
`define TIR_CF_CHAN_LSB 0
`define TIR_CF_TYPE_LSB 4
`define TIR_CF_FAHR 8
`define TIR_CF_FAST 9
`define TIR_CF_BURN_LSB 10
`define TIR_CONFIG_RST 32'h0000_0407
`define TIR_SENSOR_LAST 3'h5
`define TIR_BURN_OFF 2'h0
`define TIR_BURN_LOW 2'h1
`define TIR_BURN_HIGH 2'h2
`define TIR_SC_EN 0
`define TIR_SC_CLAMP 1
`define TIR_RAWLIM_RST 32'h7FFF_8000
`define TIR_ENGMIN_RST 32'h0000_0000
`define TIR_ENGMAX_RST 32'h0000_0064
`define TIR_C_MIN 16'hFE70
`define TIR_C_MAX 16'h05DC
`define TIR_F_MAX 16'h0BCC
`define TIR_F_OFFS 16'h0140
`define TIR_RAW_LO 16'h8000
`define TIR_RAW_HI 16'h7FFF
`define TIR_FRAC 16
`define TIR_DIV_STEPS 6'h31
`define TIR_RESP_OKAY 2'h0
`define TIR_RESP_SLVERR 2'h2
`endif

/* tir_readout.v */
// Thermistor input readout: sequencer, status flags, scaling, AXI4-Lite registers
`timescale 1ns/1ps
`include "tir_defs.vh"
module tir_readout #(
  parameter SLOW_CYC = `TIR_SLOW_NS / `TIR_CLK_NS,
  parameter FAST_CYC = `TIR_FAST_NS / `TIR_CLK_NS
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg conv_start_o,
  output reg [2:0] conv_chan_o,
  output reg [2:0] conv_type_o,
  output reg conv_fast_o,
  input wire meas_valid_i,
  input wire [2:0] meas_chan_i,
  input wire [15:0] meas_temp_c_i,
  input wire meas_open_i,
  input wire self_test_fail_i,
  input wire supply_ok_i
);

  // Register bus state
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [31:0] cfg_shadow_ff;
  reg [31:0] cfg_ff;
  reg [1:0] scale_ff;
  reg [31:0] rawlim_ff;
  reg [31:0] engmin_ff;
  reg [31:0] engmax_ff;
  reg cfg_bad_ff;
  reg cfg_pend_ff;
  reg [31:0] upc_ff;
  // Sequencer and per channel state
  reg [31:0] tick_ff;
  reg [2:0] chan_ff;
  reg [7:0] range_ff;
  reg [7:0] open_ff;
  reg [15:0] raw_mem [0:7];
  reg [31:0] scl_mem [0:7];
  // Divider state
  reg div_busy_ff;
  reg [5:0] div_cnt_ff;
  reg [48:0] div_quo_ff;
  reg [17:0] div_rem_ff;
  reg [16:0] div_den_ff;
  reg div_neg_ff;

  wire do_write;
  wire do_read;
  wire [31:0] wmask;
  wire [2:0] act_last;
  wire [2:0] act_type;
  wire act_fahr;
  wire act_fast;
  wire [1:0] act_burn;
  wire cfg_legal;
  wire sweep_start;
  wire [31:0] tick_lim;
  wire [23:0] status;
  wire signed [15:0] raw_min;
  wire signed [15:0] raw_max;

  assign s_axi_awready_o = !aw_got_ff && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_got_ff && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid_o;
  assign do_read = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign act_last = cfg_ff[`TIR_CF_CHAN_LSB +: 3];
  assign act_type = cfg_ff[`TIR_CF_TYPE_LSB +: 3];
  assign act_fahr = cfg_ff[`TIR_CF_FAHR];
  assign act_fast = cfg_ff[`TIR_CF_FAST];
  assign act_burn = cfg_ff[`TIR_CF_BURN_LSB +: 2];
  assign raw_min = rawlim_ff[15:0];
  assign raw_max = rawlim_ff[31:16];
  assign cfg_legal = (cfg_shadow_ff[`TIR_CF_TYPE_LSB +: 3] <= `TIR_SENSOR_LAST) &&
                     (cfg_shadow_ff[`TIR_CF_BURN_LSB +: 2] != 2'h3);
  // sample period from the rate setting
  assign tick_lim = act_fast ? FAST_CYC[31:0] : SLOW_CYC[31:0];
  // sweep wraps after the last enabled channel
  assign sweep_start = (tick_ff == tick_lim - 32'h1) && (chan_ff == act_last);
  // one 24-bit word, one byte per flag group
  // module byte, upper five bits zero
  assign status = {open_ff, range_ff, 5'h00, cfg_bad_ff, !supply_ok_i, self_test_fail_i};

  // Write address and data are taken independently
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `TIR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if ({awaddr_ff[7:2], 2'b00} == `TIR_A_CONFIG || {awaddr_ff[7:2], 2'b00} == `TIR_A_SCALE ||
            {awaddr_ff[7:2], 2'b00} == `TIR_A_RAWLIM || {awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMIN ||
            {awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMAX)
          s_axi_bresp_o <= `TIR_RESP_OKAY;
        else
          s_axi_bresp_o <= `TIR_RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // Config writes land in a shadow; the sequencer adopts them at sweep start
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_shadow_ff <= `TIR_CONFIG_RST;
      cfg_ff <= `TIR_CONFIG_RST;
      scale_ff <= 2'h0;
      rawlim_ff <= `TIR_RAWLIM_RST;
      engmin_ff <= `TIR_ENGMIN_RST;
      engmax_ff <= `TIR_ENGMAX_RST;
      cfg_pend_ff <= 1'b0;
      cfg_bad_ff <= 1'b1;
    end
    else
    begin
      if (do_write)
      begin
        if ({awaddr_ff[7:2], 2'b00} == `TIR_A_CONFIG)
          cfg_shadow_ff <= (cfg_shadow_ff & ~wmask) | (wdata_ff & wmask);
        else if ({awaddr_ff[7:2], 2'b00} == `TIR_A_SCALE)
          scale_ff <= wstrb_ff[0] ? wdata_ff[1:0] : scale_ff;
        else if ({awaddr_ff[7:2], 2'b00} == `TIR_A_RAWLIM)
          rawlim_ff <= (rawlim_ff & ~wmask) | (wdata_ff & wmask);
        else if ({awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMIN)
          engmin_ff <= (engmin_ff & ~wmask) | (wdata_ff & wmask);
        else if ({awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMAX)
          engmax_ff <= (engmax_ff & ~wmask) | (wdata_ff & wmask);
      end
      // any accepted setting write makes the module stale
      if (do_write && {awaddr_ff[7:2], 2'b00} >= `TIR_A_CONFIG &&
          {awaddr_ff[7:2], 2'b00} <= `TIR_A_ENGMAX)
      begin
        cfg_pend_ff <= 1'b1;
        cfg_bad_ff <= 1'b1;
      end
      else if (cfg_pend_ff && sweep_start && !div_busy_ff && cfg_legal)
      begin
        cfg_ff <= cfg_shadow_ff;
        cfg_pend_ff <= 1'b0;
        cfg_bad_ff <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `TIR_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `TIR_RESP_OKAY;
      if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_STATUS)
        s_axi_rdata_o <= {8'h00, status};
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_CONFIG)
        s_axi_rdata_o <= cfg_shadow_ff;
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_SCALE)
        s_axi_rdata_o <= {30'h0000_0000, scale_ff};
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_RAWLIM)
        s_axi_rdata_o <= rawlim_ff;
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_ENGMIN)
        s_axi_rdata_o <= engmin_ff;
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_ENGMAX)
        s_axi_rdata_o <= engmax_ff;
      else if ({s_axi_araddr_i[7:2], 2'b00} == `TIR_A_UPC)
        s_axi_rdata_o <= upc_ff;
      // raw word sign-extended into the bus word
      else if (s_axi_araddr_i >= `TIR_A_RAW0 && s_axi_araddr_i < `TIR_A_SCL0)
        s_axi_rdata_o <= {{16{raw_mem[s_axi_araddr_i[4:2]][15]}}, raw_mem[s_axi_araddr_i[4:2]]};
      else if (s_axi_araddr_i >= `TIR_A_SCL0 && s_axi_araddr_i < `TIR_A_END)
        s_axi_rdata_o <= scl_mem[s_axi_araddr_i[4:2]];
      else
      begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= `TIR_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // factor = (eng span << 16) / raw span, recomputed after each limit write
  // Serial divider trades 51 cycles of latency for no wide combinational divide
  always @(posedge mclk_i or negedge rst_n_i)
  begin : div_blk
    reg [33:0] span_e;
    reg [16:0] span_r;
    reg [17:0] rem_sh;
    span_e = 34'h0_0000_0000;
    span_r = 17'h0_0000;
    rem_sh = 18'h0_0000;
    if (!rst_n_i)
    begin
      div_busy_ff <= 1'b1;
      div_cnt_ff <= 6'h00;
      div_quo_ff <= 49'h0_0000_0000_0000;
      div_rem_ff <= 18'h0_0000;
      div_den_ff <= 17'h0_0000;
      div_neg_ff <= 1'b0;
      upc_ff <= 32'h0000_0000;
    end
    else if (do_write && ({awaddr_ff[7:2], 2'b00} == `TIR_A_RAWLIM ||
             {awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMIN || {awaddr_ff[7:2], 2'b00} == `TIR_A_ENGMAX))
    begin
      div_busy_ff <= 1'b1;
      div_cnt_ff <= 6'h00;
    end
    else if (div_busy_ff && div_cnt_ff == 6'h00)
    begin
      span_e = {engmax_ff[31], engmax_ff[31], engmax_ff} - {engmin_ff[31], engmin_ff[31], engmin_ff};
      span_r = {raw_max[15], raw_max} - {raw_min[15], raw_min};
      div_neg_ff <= span_e[33] ^ span_r[16];
      div_quo_ff <= {(span_e[33] ? -span_e[32:0] : span_e[32:0]), 16'h0000};
      div_den_ff <= span_r[16] ? -span_r : span_r;
      div_rem_ff <= 18'h0_0000;
      div_cnt_ff <= 6'h01;
    end
    else if (div_busy_ff && div_cnt_ff <= `TIR_DIV_STEPS)
    begin
      rem_sh = {div_rem_ff[16:0], div_quo_ff[48]};
      if (rem_sh >= {1'b0, div_den_ff})
      begin
        div_rem_ff <= rem_sh - {1'b0, div_den_ff};
        div_quo_ff <= {div_quo_ff[47:0], 1'b1};
      end
      else
      begin
        div_rem_ff <= rem_sh;
        div_quo_ff <= {div_quo_ff[47:0], 1'b0};
      end
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
    else if (div_busy_ff)
    begin
      // Zero raw span gives a zero factor rather than garbage
      if (div_den_ff == 17'h0_0000)
        upc_ff <= 32'h0000_0000;
      else
        upc_ff <= div_neg_ff ? -div_quo_ff[31:0] : div_quo_ff[31:0];
      div_busy_ff <= 1'b0;
    end
  end

  // Sample pacing and channel rotation
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_ff <= 32'h0000_0000;
      chan_ff <= 3'h0;
      conv_start_o <= 1'b0;
      conv_chan_o <= 3'h0;
      conv_type_o <= 3'h0;
      conv_fast_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      if (tick_ff >= tick_lim - 32'h1)
      begin
        tick_ff <= 32'h0000_0000;
        // only channels up to the count are converted
        chan_ff <= (chan_ff >= act_last) ? 3'h0 : chan_ff + 3'h1;
        conv_start_o <= 1'b1;
        conv_chan_o <= (chan_ff >= act_last) ? 3'h0 : chan_ff + 3'h1;
        // converter linearizes for the chosen sensor
        conv_type_o <= act_type;
        // converter runs at the chosen rate
        conv_fast_o <= act_fast;
      end
      else
        tick_ff <= tick_ff + 32'h0000_0001;
    end
  end

  // Per channel result capture
  genvar g;
  generate
    for (g = 0; g < `TIR_NCHAN; g = g + 1)
    begin : ch
      reg signed [15:0] deg;
      reg signed [19:0] f_wide;
      reg signed [15:0] hi;
      reg signed [15:0] word;
      reg signed [16:0] diff;
      reg signed [48:0] prod;
      reg signed [31:0] scl;
      reg over;
      always @*
      begin
        // Fahrenheit tenths are C*9/5 + 320
        // C span -400..1500, F span -400..3020
        // Widened so the times-nine product cannot wrap
        f_wide = ($signed({{4{meas_temp_c_i[15]}}, meas_temp_c_i}) * 20'sd9) / 20'sd5;
        deg = act_fahr ? f_wide[15:0] + `TIR_F_OFFS : meas_temp_c_i;
        hi = act_fahr ? `TIR_F_MAX : `TIR_C_MAX;
        over = ($signed(meas_temp_c_i) < $signed(`TIR_C_MIN)) ||
               ($signed(meas_temp_c_i) > $signed(`TIR_C_MAX));
        // broken loop forces the word low or high
        if (meas_open_i && act_burn == `TIR_BURN_LOW)
          word = `TIR_RAW_LO;
        else if (meas_open_i && act_burn == `TIR_BURN_HIGH)
          word = `TIR_RAW_HI;
        else if (over)
          word = ($signed(meas_temp_c_i) < $signed(`TIR_C_MIN)) ? $signed(`TIR_C_MIN) : hi;
        else
          word = deg;
        // linear map from raw limits onto engineering limits
        diff = {word[15], word} - {raw_min[15], raw_min};
        prod = diff * $signed(upc_ff);
        scl = prod[47:16] + $signed(engmin_ff);
        if (scale_ff[`TIR_SC_CLAMP] && scl < $signed(engmin_ff))
          scl = engmin_ff;
        else if (scale_ff[`TIR_SC_CLAMP] && scl > $signed(engmax_ff))
          scl = engmax_ff;
      end
      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          raw_mem[g] <= 16'h0000;
          scl_mem[g] <= 32'h0000_0000;
          range_ff[g] <= 1'b0;
          open_ff[g] <= 1'b0;
        end
        else if (meas_valid_i && {29'h0, meas_chan_i} == g && meas_chan_i <= act_last)
        begin
          raw_mem[g] <= word;
          // scaled value only while scaling is enabled
          scl_mem[g] <= scale_ff[`TIR_SC_EN] ? scl : 32'h0000_0000;
          // out-of-range flag at bit of its channel
          range_ff[g] <= over && !meas_open_i;
          // broken-loop flag at bit of its channel
          open_ff[g] <= meas_open_i && (act_burn != `TIR_BURN_OFF);
        end
      end
    end
  endgenerate

endmodule // tir_readout

/* tir_readout_sva.sv */
// Port-level checker for the thermistor readout block
`timescale 1ns/1ps
`include "tir_defs.vh"
module tir_readout_sva #(
  parameter SLOW_CYC = 40,
  parameter FAST_CYC = 20
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire conv_start_o,
  input wire [2:0] conv_type_o,
  input wire self_test_fail_i,
  input wire supply_ok_i
);
  reg [31:0] gap_ff;
  reg seen_ff;
  reg [7:0] rd_addr_ff;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // First start after reset has no reference gap
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gap_ff <= 32'h0;
      seen_ff <= 1'b0;
      rd_addr_ff <= 8'h00;
    end
    else
    begin
      gap_ff <= conv_start_o ? 32'h0 : gap_ff + 32'h1;
      seen_ff <= seen_ff | conv_start_o;
      if (s_axi_arvalid_i && s_axi_arready_o)
        rd_addr_ff <= s_axi_araddr_i;
    end
  end
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // Status read taken; the flag checks below add the live inputs steady over the take
  sequence s_stat_rd;
    s_rd_take ##0 (s_axi_araddr_i == `TIR_A_STATUS);
  endsequence
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_rd_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  a_wr_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  a_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == `TIR_RESP_SLVERR
    |-> s_axi_rdata_o == 32'h0)
    else $error("refused read returned data");
  a_status_pad: assert property (s_axi_rvalid_o && rd_addr_ff == `TIR_A_STATUS
    |-> s_axi_rdata_o[31:24] == 8'h00 && s_axi_rdata_o[7:3] == 5'h00)
    else $error("unused status bits set");
  a_supply_flag: assert property (s_stat_rd ##0 $stable(supply_ok_i)
    |=> s_axi_rdata_o[1] == !$past(supply_ok_i))
    else $error("supply flag wrong");
  a_selftest_flag: assert property (s_stat_rd ##0 $stable(self_test_fail_i)
    |=> s_axi_rdata_o[0] == $past(self_test_fail_i))
    else $error("self-test flag wrong");
  a_type_legal: assert property (conv_type_o <= `TIR_SENSOR_LAST)
    else $error("sensor type out of range");
  a_start_gap: assert property (conv_start_o && seen_ff |-> gap_ff >= FAST_CYC - 1)
    else $error("conversion starts too close");
endmodule // tir_readout_sva
bind tir_readout tir_readout_sva #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_sva (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .conv_start_o(conv_start_o), .conv_type_o(conv_type_o),
  .self_test_fail_i(self_test_fail_i), .supply_ok_i(supply_ok_i)
);

/* tir_conv_model.sv */
// Behavioural converter front end answering conversion starts
`timescale 1ns/1ps
module tir_conv_model (
  input wire mclk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [2:0] chan_i,
  input wire [3:0] lat_i,
  input wire [15:0] base_i,
  input wire [7:0] open_i,
  output reg valid_o,
  output reg [2:0] chan_o,
  output reg [15:0] temp_o,
  output reg open_o
);
  reg [3:0] cnt_ff;
  reg [2:0] ch_ff;
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 4'h0;
      ch_ff <= 3'h0;
      valid_o <= 1'b0;
      chan_o <= 3'h0;
      temp_o <= 16'h0000;
      open_o <= 1'b0;
    end
    else
    begin
      valid_o <= 1'b0;
      // Result lines are junk outside the valid cycle
      if (valid_o)
      begin
        chan_o <= ~chan_o;
        temp_o <= ~temp_o;
        open_o <= ~open_o;
      end
      if (start_i)
      begin
        cnt_ff <= lat_i;
        ch_ff <= chan_i;
      end
      else if (cnt_ff != 4'h0)
      begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h1)
        begin
          valid_o <= 1'b1;
          chan_o <= ch_ff;
          temp_o <= base_i + {13'h0, ch_ff};
          open_o <= open_i[ch_ff];
        end
      end
    end
  end
endmodule // tir_conv_model

/* tb.sv */
// Self-checking bench for the thermistor readout block
`timescale 1ns/1ps
`include "tir_defs.vh"
module tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic stf = 1'b0;
  logic sok = 1'b1;
  logic [3:0] lat = 4'h1;
  logic [15:0] base = 16'h0000;
  logic [7:0] opn = 8'h00;
  logic [2:0] mx;
  int bad_count = 0;
  int cmp_count = 0;
  wire awready, wready, bvalid, arready, rvalid, cstart, cfast, mval, mopen;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] cchan, ctype, mchan;
  wire [15:0] mtemp;
  always #2 mclk_i = ~mclk_i;
  tir_readout #(.SLOW_CYC(40), .FAST_CYC(20)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .conv_start_o(cstart), .conv_chan_o(cchan),
    .conv_type_o(ctype), .conv_fast_o(cfast), .meas_valid_i(mval),
    .meas_chan_i(mchan), .meas_temp_c_i(mtemp), .meas_open_i(mopen),
    .self_test_fail_i(stf), .supply_ok_i(sok)
  );
  tir_conv_model u_conv (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(cstart), .chan_i(cchan),
    .lat_i(lat), .base_i(base), .open_i(opn), .valid_o(mval), .chan_o(mchan),
    .temp_o(mtemp), .open_o(mopen)
  );
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task fail(input string n);
    bad_count++;
    $display("[ERR] %s wait expected done seen timeout", n);
    print_verdict;
  endtask
  // Ready sampled mid-cycle so the release lands right after the taking edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd, ta, tw, bv;
    logic [1:0] rs;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    bv = 1'b0;
    n = 0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!bv && n < 100)
    begin
      @(negedge mclk_i);
      ta = awready && !ad;
      tw = wready && !wd;
      bv = ad && wd && bvalid;
      rs = bresp;
      @(posedge mclk_i);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      ad = ad | ta;
      wd = wd | tw;
      n++;
    end
    if (!bv)
      fail("write");
    chk("bresp", {30'h0, rs}, {30'h0, r});
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, got;
    int n;
    got = 1'b0;
    n = 0;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    while (!got && n < 100)
    begin
      @(negedge mclk_i);
      ta = arvalid && arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk_i);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    if (!got)
      fail("read");
  endtask
  task rck(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(s, d, e);
    chk("rresp", {30'h0, r}, {30'h0, `TIR_RESP_OKAY});
  endtask
  task starts(input int k);
    int n;
    n = 0;
    mx = 3'h0;
    while (k > 0 && n < 5000)
    begin
      @(negedge mclk_i);
      if (cstart)
      begin
        k--;
        if (cchan > mx)
          mx = cchan;
      end
      n++;
    end
    if (k > 0)
      fail("start");
  endtask
  task settle;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    d = 32'h4;
    while (d[`TIR_ST_CFGBAD] && n < 200)
    begin
      rd(`TIR_A_STATUS, d, r);
      n++;
    end
    if (d[`TIR_ST_CFGBAD])
      fail("config");
    starts(9);
  endtask
  task setc(input logic [31:0] c);
    wr(`TIR_A_CONFIG, c, `TIR_RESP_OKAY);
    settle;
  endtask
  task t_reset;
    rck("status", `TIR_A_STATUS, 32'h0000_0004);
    rck("config", `TIR_A_CONFIG, `TIR_CONFIG_RST);
    rck("rawlim", `TIR_A_RAWLIM, `TIR_RAWLIM_RST);
    rck("engmax", `TIR_A_ENGMAX, `TIR_ENGMAX_RST);
    starts(2);
    chk("fast", {31'h0, cfast}, 32'h0);
  endtask
  task t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h60, d, r);
    chk("rresp", {30'h0, r}, {30'h0, `TIR_RESP_SLVERR});
    chk("rdata", d, 32'h0);
    wr(`TIR_A_STATUS, 32'hFFFF_FFFF, `TIR_RESP_SLVERR);
    wr(`TIR_A_UPC, 32'h0000_0001, `TIR_RESP_SLVERR);
    wr(8'h7C, 32'h0000_0001, `TIR_RESP_SLVERR);
    rck("status", `TIR_A_STATUS, 32'h0000_0004);
  endtask
  task t_live;
    @(posedge mclk_i);
    stf <= 1'b1;
    sok <= 1'b0;
    rck("status", `TIR_A_STATUS, 32'h0000_0007);
    @(posedge mclk_i);
    stf <= 1'b0;
    sok <= 1'b1;
    rck("status", `TIR_A_STATUS, 32'h0000_0004);
  endtask
  // Channels 4..8 sit just above the Celsius span end
  task t_range;
    base <= 16'h05DA;
    setc(32'h0000_0607);
    chk("fast", {31'h0, cfast}, 32'h1);
    rck("status", `TIR_A_STATUS, 32'h0000_F800);
    rck("raw1", `TIR_A_RAW0, 32'h0000_05DA);
    rck("raw8", `TIR_A_RAW0 + 8'h1C, 32'h0000_05DC);
  endtask
  task t_burn;
    logic [1:0] code;
    logic [31:0] d;
    logic [1:0] r;
    base <= 16'h00FA;
    opn <= 8'h81;
    lat <= 4'hF;
    for (int i = 0; i < 3; i++)
    begin
      code = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h0;
      setc({20'h0, code, 10'h207});
      rd(`TIR_A_STATUS, d, r);
      chk("broken", d & 32'hFFFF_00FF, (i < 2) ? 32'h0081_0000 : 32'h0);
      rck("raw1", `TIR_A_RAW0, (i == 0) ? 32'hFFFF_8000 : (i == 1) ? 32'h7FFF : 32'hFA);
      rck("raw2", `TIR_A_RAW0 + 8'h04, 32'h0000_00FB);
    end
    opn <= 8'h00;
  endtask
  task t_fahr;
    base <= 16'h03E8;
    setc(32'h0000_0307);
    rck("raw1", `TIR_A_RAW0, 32'h0000_0848);
    rck("raw8", `TIR_A_RAW0 + 8'h1C, 32'h0000_0854);
    rck("scl1", `TIR_A_SCL0, 32'h0);
  endtask
  // Limits chosen so the factor is exactly a quarter
  task t_scale;
    wr(`TIR_A_CONFIG, 32'h0000_0207, `TIR_RESP_OKAY);
    wr(`TIR_A_SCALE, 32'h0000_0001, `TIR_RESP_OKAY);
    wr(`TIR_A_RAWLIM, 32'h0400_0000, `TIR_RESP_OKAY);
    wr(`TIR_A_ENGMAX, 32'h0000_0100, `TIR_RESP_OKAY);
    settle;
    rck("upc", `TIR_A_UPC, 32'h0000_4000);
    rck("scl1", `TIR_A_SCL0, 32'h0000_00FA);
    rck("scl8", `TIR_A_SCL0 + 8'h1C, 32'h0000_00FB);
    wr(`TIR_A_SCALE, 32'h0000_0003, `TIR_RESP_OKAY);
    wr(`TIR_A_ENGMAX, 32'h0000_0080, `TIR_RESP_OKAY);
    wr(`TIR_A_RAWLIM, 32'h0200_0000, `TIR_RESP_OKAY);
    settle;
    rck("scl1", `TIR_A_SCL0, 32'h0000_0080);
  endtask
  task t_types;
    logic [31:0] d;
    logic [1:0] r;
    for (int t = 0; t < 6; t++)
    begin
      setc({25'h0, t[2:0], 4'h0} | 32'h0000_0201);
      chk("type", {29'h0, ctype}, t);
      chk("maxchan", {29'h0, mx}, 32'h1);
    end
    wr(`TIR_A_CONFIG, 32'h0000_0261, `TIR_RESP_OKAY);
    starts(4);
    rd(`TIR_A_STATUS, d, r);
    chk("cfgbad", {31'h0, d[`TIR_ST_CFGBAD]}, 32'h1);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_bus;
    t_live;
    t_range;
    t_burn;
    t_fahr;
    t_scale;
    t_types;
    print_verdict;
  end
endmodule // tb
